//--- rtl/cpl_panel.sv
// Console panel control logic: display selectors, console registers,
// breakpoint compare, run controls and maintenance overrides.
// Assumes panel inputs are synchronous to core_clk; presses are debounced here.
//
// How it works
// [R1] - Eleven data sources to data lamps; most need maintenance mode.
// [R2] - Clear-data press zeroes the console data register.
// [R3] - Each data pushbutton sets only its own console data bit.
// [R4] - Data lamps show the selected data source bit by bit.
// [R5] - Data lamp bits 13 to 15 also feed the speaker outputs.
// [R6] - Four address sources to address lamps; two need maintenance mode.
// [R7] - Clear-address press zeroes the console address register.
// [R8] - Each address pushbutton sets only its own console address bit.
// [R9] - Write-data breakpoint stops after a storage write at the address.
// [R10] - Read-data breakpoint stops after a storage read at the address.
// [R11] - Instruction breakpoint stops after a fetch from the address.
// [R12] - Relocate switch picks system or physical address for compare/display.
// [R13] - Breakpoint address is five hex digits from selectors.
// [R14] - Eight states each have stop/step, run, or run-to-breakpoint.
// [R15] - Step unit is instruction, or major cycle when cycle-step on.
// [R16] - Executive inhibit suppresses periodic autostart of state 4.
// [R17] - Control-store inhibit forces control-store words to zero.
// [R18] - Parity inhibit blocks parity stops/traps, keeps indicators.
// [R19] - Each even-parity toggle press flips its byte parity; odd default.
// [R20] - Maintenance group controls work only in maintenance mode.
// [R21] - Left feeder force loads ones into the left ALU feeder.
// [R22] - Both forces held: ones into storage data and forced carry.
// [R23] - Panel inputs are debounced; each press is one event.
`timescale 1ns/10ps
module cpl_panel #(
   parameter int DW = 16,
   parameter int AW = 20,
   parameter int CSW = 32,
   parameter int DEBOUNCE_CYC = cpl_pkg::DEBOUNCE_CYC,
   parameter int RTC_PERIOD_CYC = cpl_pkg::RTC_PERIOD_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DW-1:0] data_btn,
   input wire logic [DW-1:0] addr_btn,
   input wire logic clear_data_btn,
   input wire logic clear_addr_btn,
   input wire logic even_par0_btn,
   input wire logic even_par1_btn,
   input wire logic force_left_btn,
   input wire logic force_right_btn,
   input wire logic [DW-1:0] micro_function_rank_two,
   input wire logic [DW-1:0] micro_function_rank_one,
   input wire logic [DW-1:0] rtc_value,
   input wire logic [DW-1:0] control_store_scan_register,
   input wire logic [DW-1:0] busy_active_register,
   input wire logic [DW-1:0] ms_data_register,
   input wire logic [DW-1:0] alu_feeder_left,
   input wire logic [DW-1:0] alu_feeder_right,
   input wire logic [DW-1:0] alu_sum,
   input wire logic [DW-1:0] boundary_crossing_register,
   input wire logic [AW-1:0] ms_sys_addr,
   input wire logic [AW-1:0] ms_phys_addr,
   input wire logic [AW-1:0] control_store_address_register,
   input wire logic [AW-1:0] parity_error_address_register,
   input wire logic [CSW-1:0] cs_word_in,
   input wire logic ms_ref_end,
   input wire logic ms_ref_write,
   input wire logic instr_fetch_done,
   input wire logic [2:0] active_state,
   input wire logic ms_par_err,
   input wire logic cs_par_err,
   output logic [DW-1:0] data_lamps,
   output logic [2:0] speaker_drive,
   output logic [AW-1:0] addr_lamps,
   output logic bkpt_stop,
   output logic [7:0] state_run_en,
   output logic [7:0] state_bkpt_mode,
   output logic step_major_cycle,
   output logic exec_autostart,
   output logic [CSW-1:0] cs_word_out,
   output logic parity_stop,
   output logic ms_par_ind,
   output logic cs_par_ind,
   output logic [1:0] even_parity,
   output logic load_left_ones,
   output logic load_msdata_ones,
   output logic force_carry
);
   localparam int NBTN = 2 * DW + 6;
   localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
   localparam int RTW = $clog2(RTC_PERIOD_CYC + 1);
   default clocking cpl_cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // ----------------------------------------------------------
   // Debounce
   // ----------------------------------------------------------
   logic [NBTN-1:0] raw_in, deb, deb_q, press;
   assign raw_in = {force_right_btn, force_left_btn, even_par1_btn, even_par0_btn,
                    clear_addr_btn, clear_data_btn, addr_btn, data_btn};

   genvar gi;
   generate
      for (gi = 0; gi < NBTN; gi++) begin : g_deb
         logic [DBW-1:0] cnt;
         always_ff @(posedge core_clk) begin
            if (srst) begin
               cnt <= '0;
               deb[gi] <= 1'b0;
            end else if (raw_in[gi] == deb[gi]) begin
               cnt <= '0;
            end else if (cnt == DBW'(DEBOUNCE_CYC - 1)) begin
               cnt <= '0;
               deb[gi] <= raw_in[gi]; // [R23]
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate
   always_ff @(posedge core_clk) begin
      deb_q <= srst ? '0 : deb;
   end
   assign press = deb & ~deb_q; // [R23]
   wire logic [DW-1:0] data_press = press[DW-1:0];
   wire logic [DW-1:0] addr_press = press[2*DW-1:DW];
   wire logic clr_d = press[2*DW];
   wire logic clr_a = press[2*DW+1];
   wire logic par0_press = press[2*DW+2];
   wire logic par1_press = press[2*DW+3];
   wire logic left_held = deb[2*DW+4];
   wire logic right_held = deb[2*DW+5];
   // ----------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------
   logic [31:0] ctrl, bkpt, runctl;
   logic [DW-1:0] cdata;
   logic [AW-1:0] caddr;
   logic [7:0] aw_q;
   logic aw_held, w_held;
   logic [31:0] w_q;
   wire logic maint = ctrl[cpl_pkg::B_MAINT];
   wire logic do_wr = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cpl_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_q <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_q > cpl_pkg::OFF_STATUS || aw_q[1:0] != 2'h0) ?
                           cpl_pkg::RESP_SLVERR : cpl_pkg::RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      s_axi_awready <= !srst && !((aw_held || (s_axi_awvalid && s_axi_awready)) && !do_wr);
      s_axi_wready <= !srst && !((w_held || (s_axi_wvalid && s_axi_wready)) && !do_wr);
      s_axi_arready <= !srst && !(s_axi_arvalid && s_axi_arready) &&
                       (!s_axi_rvalid || s_axi_rready);
   end
   wire logic wr_ctrl = do_wr && aw_q == cpl_pkg::OFF_CTRL;
   wire logic wr_bkpt = do_wr && aw_q == cpl_pkg::OFF_BKPT;
   wire logic wr_run = do_wr && aw_q == cpl_pkg::OFF_RUNCTL;
   always_ff @(posedge core_clk) begin
      ctrl <= srst ? cpl_pkg::CTRL_RST : (wr_ctrl ? w_q : ctrl);
      bkpt <= srst ? '0 : (wr_bkpt ? w_q : bkpt);
      runctl <= srst ? '0 : (wr_run ? w_q : runctl);
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= cpl_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= cpl_pkg::RESP_OKAY;
         case (s_axi_araddr)
            cpl_pkg::OFF_CTRL: s_axi_rdata <= ctrl;
            cpl_pkg::OFF_BKPT: s_axi_rdata <= bkpt;
            cpl_pkg::OFF_RUNCTL: s_axi_rdata <= runctl;
            cpl_pkg::OFF_CDATA: s_axi_rdata <= 32'(cdata);
            cpl_pkg::OFF_CADDR: s_axi_rdata <= 32'(caddr);
            cpl_pkg::OFF_STATUS: s_axi_rdata <= {26'h0, bkpt_stop, even_parity,
                                                 cs_par_ind, ms_par_ind, parity_stop};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= cpl_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ----------------------------------------------------------
   // Console registers
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      cdata <= (srst || clr_d) ? '0 : cdata | data_press; // [R2] [R3]
   end
   always_ff @(posedge core_clk) begin
      caddr <= (srst || clr_a) ? '0 : caddr | AW'(addr_press); // [R7] [R8]
   end
   // ----------------------------------------------------------
   // Display selection
   // ----------------------------------------------------------
   wire logic [3:0] dsel = ctrl[cpl_pkg::DSEL_LSB +: 4];
   wire logic [1:0] asel = ctrl[cpl_pkg::ASEL_LSB +: 2];
   wire logic use_sys = ctrl[cpl_pkg::B_RELOC_INST] && ctrl[cpl_pkg::B_RELOC];
   wire logic [AW-1:0] ms_addr = use_sys ? ms_sys_addr : ms_phys_addr; // [R12]
   logic [DW-1:0] next_data_lamps;
   logic [AW-1:0] next_addr_lamps;

   always_comb begin
      next_data_lamps = '0;
      case (dsel) // [R1] [R4]
         cpl_pkg::DS_BUSY: next_data_lamps = busy_active_register;
         cpl_pkg::DS_CDATA: next_data_lamps = cdata;
         cpl_pkg::DS_FUNC2: if (maint) next_data_lamps = micro_function_rank_two;
         cpl_pkg::DS_FUNC1: if (maint) next_data_lamps = micro_function_rank_one;
         cpl_pkg::DS_RTC: if (maint) next_data_lamps = rtc_value;
         cpl_pkg::DS_SCAN: if (maint) next_data_lamps = control_store_scan_register;
         cpl_pkg::DS_MSDATA: if (maint) next_data_lamps = ms_data_register;
         cpl_pkg::DS_LEFT: if (maint) next_data_lamps = alu_feeder_left;
         cpl_pkg::DS_RIGHT: if (maint) next_data_lamps = alu_feeder_right;
         cpl_pkg::DS_SUM: if (maint) next_data_lamps = alu_sum;
         cpl_pkg::DS_BOUND: if (maint) next_data_lamps = boundary_crossing_register;
         default: next_data_lamps = '0;
      endcase
   end

   always_comb begin
      next_addr_lamps = '0;
      case (asel) // [R6]
         cpl_pkg::AS_MSADDR: next_addr_lamps = ms_addr;
         cpl_pkg::AS_CADDR: next_addr_lamps = caddr;
         cpl_pkg::AS_CSADDR: if (maint) next_addr_lamps = control_store_address_register;
         cpl_pkg::AS_PEADDR: if (maint) next_addr_lamps = parity_error_address_register;
         default: next_addr_lamps = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      data_lamps <= srst ? '0 : next_data_lamps;
      speaker_drive <= srst ? '0 : next_data_lamps[15:13]; // [R5]
      addr_lamps <= srst ? '0 : next_addr_lamps;
   end
   // ----------------------------------------------------------
   // Breakpoint and run control
   // ----------------------------------------------------------
   wire logic [AW-1:0] bk_addr = bkpt[AW-1:0]; // [R13]
   wire logic addr_eq = ms_addr == bk_addr;
   logic next_bkpt;
   always_comb begin
      next_bkpt = 1'b0;
      if (ctrl[cpl_pkg::B_BK_WR] && ms_ref_end && ms_ref_write && addr_eq) next_bkpt = 1'b1; // [R9]
      if (ctrl[cpl_pkg::B_BK_RD] && ms_ref_end && !ms_ref_write && addr_eq) next_bkpt = 1'b1; // [R10]
      if (ctrl[cpl_pkg::B_BK_IF] && instr_fetch_done && addr_eq) next_bkpt = 1'b1; // [R11]
      if (runctl[2*active_state +: 2] != cpl_pkg::RUN_BKPT) next_bkpt = 1'b0; // [R14]
   end

   logic [RTW-1:0] rtc_cnt;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rtc_cnt <= '0;
         exec_autostart <= 1'b0;
      end else begin
         exec_autostart <= 1'b0;
         if (rtc_cnt == RTW'(RTC_PERIOD_CYC - 1)) begin
            rtc_cnt <= '0;
            exec_autostart <= !(maint && ctrl[cpl_pkg::B_EXEC_INH]); // [R16] [R20]
         end else begin
            rtc_cnt <= rtc_cnt + 1'b1;
         end
      end
   end

   generate
      for (gi = 0; gi < 8; gi++) begin : g_state
         always_ff @(posedge core_clk) begin
            state_run_en[gi] <= !srst && runctl[2*gi +: 2] != cpl_pkg::RUN_STOP; // [R14]
            state_bkpt_mode[gi] <= !srst && runctl[2*gi +: 2] == cpl_pkg::RUN_BKPT;
         end
      end
   endgenerate
   // ----------------------------------------------------------
   // Maintenance overrides
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bkpt_stop <= 1'b0;
         step_major_cycle <= 1'b0;
         cs_word_out <= '0;
         parity_stop <= 1'b0;
         ms_par_ind <= 1'b0;
         cs_par_ind <= 1'b0;
         load_left_ones <= 1'b0;
         load_msdata_ones <= 1'b0;
         force_carry <= 1'b0;
      end else begin
         bkpt_stop <= next_bkpt;
         step_major_cycle <= maint && ctrl[cpl_pkg::B_CYCSTEP]; // [R15] [R20]
         cs_word_out <= (maint && ctrl[cpl_pkg::B_CS_INH]) ? '0 : cs_word_in; // [R17]
         parity_stop <= (ms_par_err || cs_par_err) &&
                        !(maint && ctrl[cpl_pkg::B_PAR_INH]); // [R18]
         ms_par_ind <= ms_par_err;
         cs_par_ind <= cs_par_err;
         load_left_ones <= maint && left_held && !right_held; // [R21]
         load_msdata_ones <= maint && left_held && right_held; // [R22]
         force_carry <= maint && left_held && right_held; // [R22]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         even_parity <= 2'h0; // [R19]
      end else if (maint) begin
         even_parity <= even_parity ^ {par1_press, par0_press}; // [R19] [R20]
      end
   end
   bkpt_when_wr_a: assert property ((ctrl[cpl_pkg::B_BK_WR] && ms_ref_end && ms_ref_write // [R9]
      && addr_eq && runctl[2*active_state +: 2] == cpl_pkg::RUN_BKPT) |=> bkpt_stop)
      else $error("write breakpoint missed");
   clear_data_a: assert property (clr_d |=> cdata == '0) else $error("data not cleared"); // [R2]
   clear_addr_a: assert property (clr_a |=> caddr == '0) else $error("addr not cleared"); // [R7]
   speaker_bits_a: assert property (speaker_drive == data_lamps[15:13]) // [R5]
      else $error("speaker mismatch");
   cs_zero_a: assert property ((maint && ctrl[cpl_pkg::B_CS_INH]) |=> cs_word_out == '0) // [R17]
      else $error("control store not forced");
   par_keep_a: assert property (ms_par_err |=> ms_par_ind) else $error("indicator lost"); // [R18]
   par_toggle_a: assert property ((maint && par0_press) // [R19]
      |=> even_parity[0] != $past(even_parity[0])) else $error("parity toggle failed");
   both_force_a: assert property ((maint && left_held && right_held) // [R22]
      |=> (force_carry && !load_left_ones)) else $error("dual force wrong");
   data_mask_a: assert property ((!maint && dsel == cpl_pkg::DS_SUM) |=> data_lamps == '0) // [R1]
      else $error("maintenance source leaked");
endmodule : cpl_panel

//--- rtl/cpl_pkg.sv
// Constants and types for the console panel control logic.
// Assumes a single 50 MHz clock and a 32-bit AXI4-Lite register bus.
package cpl_pkg;
   localparam int CLK_HZ = 50000000;
   localparam int DEBOUNCE_US = 5000;
   localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
   localparam int RTC_PERIOD_US = 16300;
   localparam int RTC_PERIOD_CYC = (CLK_HZ / 1000000) * RTC_PERIOD_US;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_BKPT = 8'h04;
   localparam logic [7:0] OFF_RUNCTL = 8'h08;
   localparam logic [7:0] OFF_CDATA = 8'h0c;
   localparam logic [7:0] OFF_CADDR = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   // Control register bit positions
   localparam int B_MAINT = 0;
   localparam int B_CYCSTEP = 1;
   localparam int B_EXEC_INH = 2;
   localparam int B_CS_INH = 3;
   localparam int B_PAR_INH = 4;
   localparam int B_RELOC = 5;
   localparam int B_BK_WR = 6;
   localparam int B_BK_RD = 7;
   localparam int B_BK_IF = 8;
   localparam int B_RELOC_INST = 9;
   localparam int DSEL_LSB = 12;
   localparam int ASEL_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Data display sources
   localparam logic [3:0] DS_FUNC2 = 4'h0;
   localparam logic [3:0] DS_FUNC1 = 4'h1;
   localparam logic [3:0] DS_RTC = 4'h2;
   localparam logic [3:0] DS_SCAN = 4'h3;
   localparam logic [3:0] DS_BUSY = 4'h4;
   localparam logic [3:0] DS_CDATA = 4'h5;
   localparam logic [3:0] DS_MSDATA = 4'h6;
   localparam logic [3:0] DS_LEFT = 4'h7;
   localparam logic [3:0] DS_RIGHT = 4'h8;
   localparam logic [3:0] DS_SUM = 4'h9;
   localparam logic [3:0] DS_BOUND = 4'ha;
   // Address display sources
   localparam logic [1:0] AS_MSADDR = 2'h0;
   localparam logic [1:0] AS_CSADDR = 2'h1;
   localparam logic [1:0] AS_CADDR = 2'h2;
   localparam logic [1:0] AS_PEADDR = 2'h3;
   // Per-state run control
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_NORMAL = 2'h1;
   localparam logic [1:0] RUN_BKPT = 2'h2;
   typedef enum logic [2:0] {
      CPL_WR_IDLE = 3'b001,
      CPL_WR_RESP = 3'b010,
      CPL_WR_HOLD = 3'b100
   } cpl_wr_t;
endpackage : cpl_pkg

//--- tb/cpl_panel_model.sv
// Front panel model: holds one pushbutton, or both force buttons, for a span.
// Assumes the bench raises go for one cycle with the button code and span set.
`timescale 1ns/10ps
module cpl_panel_model (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [5:0] code,
   input wire logic [7:0] hold,
   output logic [37:0] btns
);
   int left = 0;
   logic [5:0] cur = 6'h00;
   // A press is one clean level, then let go, so it counts once
   always @(posedge core_clk) begin
      if (go) begin
         cur <= code;
         left <= hold;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   // Code 0x26 holds both force buttons together
   always_comb btns = (left == 0) ? 38'h0 : (cur == 6'h26) ? 38'h30_0000_0000 : 38'h1 << cur;
endmodule : cpl_panel_model

//--- tb/console_panel_control_logic_tb.sv
// Bench for the console panel: AXI4-Lite registers, presses, displays and stops.
// Assumes short debounce and tick spans; expectations are worked out inline in the bench.
`timescale 1ns/10ps
module console_panel_control_logic_tb;
   // ----------------
   // Signals
   // ----------------
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cs_word_in = 32'h0, cs_word_out, mreg, ex;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, go = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, even_parity;
   logic [15:0] src [11] = '{default: 16'h0};
   logic [19:0] asrc [4] = '{default: 20'h0};
   logic [15:0] data_lamps, lfsr = 16'h0393;
   logic [19:0] addr_lamps;
   logic [37:0] btns;
   logic [5:0] code = 6'h00;
   logic [7:0] hold = 8'h00, state_run_en, state_bkpt_mode;
   logic [2:0] active_state = 3'h0, speaker_drive;
   logic ms_ref_end = 1'b0, ms_ref_write = 1'b0, instr_fetch_done = 1'b0;
   logic ms_par_err = 1'b0, cs_par_err = 1'b0, bkpt_stop, step_major_cycle, exec_autostart;
   logic parity_stop, ms_par_ind, cs_par_ind, load_left_ones, load_msdata_ones, force_carry;
   int num_errors = 0, comparisons = 0, g, k, m, s, r, t, n;

   cpl_panel #(.DEBOUNCE_CYC(4), .RTC_PERIOD_CYC(50)) dut (.core_clk, .srst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .data_btn(btns[15:0]), .addr_btn(btns[31:16]),
      .clear_data_btn(btns[32]), .clear_addr_btn(btns[33]), .even_par0_btn(btns[34]),
      .even_par1_btn(btns[35]), .force_left_btn(btns[36]), .force_right_btn(btns[37]),
      .micro_function_rank_two(src[0]), .micro_function_rank_one(src[1]),
      .rtc_value(src[2]), .control_store_scan_register(src[3]),
      .busy_active_register(src[4]), .ms_data_register(src[6]), .alu_feeder_left(src[7]),
      .alu_feeder_right(src[8]), .alu_sum(src[9]), .boundary_crossing_register(src[10]),
      .ms_sys_addr(asrc[0]), .control_store_address_register(asrc[1]),
      .ms_phys_addr(asrc[2]), .parity_error_address_register(asrc[3]), .cs_word_in,
      .ms_ref_end, .ms_ref_write, .instr_fetch_done, .active_state, .ms_par_err,
      .cs_par_err, .data_lamps, .speaker_drive, .addr_lamps, .bkpt_stop, .state_run_en,
      .state_bkpt_mode, .step_major_cycle, .exec_autostart, .cs_word_out, .parity_stop,
      .ms_par_ind, .cs_par_ind, .even_parity, .load_left_ones, .load_msdata_ones,
      .force_carry);
   cpl_panel_model panel (.core_clk, .go, .code, .hold, .btns);

   always #10 core_clk = ~core_clk;

   // ----------------
   // Tasks
   // ----------------
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nx
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic tick(input int c);
      repeat (c) @(negedge core_clk);
   endtask : tick
   // Handshakes are judged at the falling edge, which shows what the next rise samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = cpl_pkg::RESP_OKAY);
      logic ha, hw, hb;
      logic [1:0] br;
      int i;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      for (i = 0; i < 40 && !hb; i++) begin
         @(negedge core_clk);
         {ha, hw, hb, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge core_clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      check("bresp", {hb, br}, {1'b1, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er = cpl_pkg::RESP_OKAY);
      logic ha, hr;
      logic [33:0] got;
      int i;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      for (i = 0; i < 40 && !hr; i++) begin
         @(negedge core_clk);
         {ha, hr, got} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
         @(posedge core_clk);
         if (ha) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      check("rdata", got[31:0], exp);
      check("rresp", {hr, got[33:32]}, {1'b1, er});
   endtask : rd
   task automatic press(input logic [5:0] c, input logic [7:0] h = 8'h08);
      @(posedge core_clk);
      code <= c;
      hold <= h;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (14) @(posedge core_clk);
   endtask : press
   task automatic ev(input int kind, input logic exp);
      int i, hits;
      @(posedge core_clk);
      ms_ref_end <= (kind != 2);
      ms_ref_write <= (kind == 0);
      instr_fetch_done <= (kind == 2);
      @(posedge core_clk);
      ms_ref_end <= 1'b0;
      instr_fetch_done <= 1'b0;
      hits = 0;
      for (i = 0; i < 6; i++) begin
         @(negedge core_clk);
         hits += bkpt_stop;
      end
      check("bkpt_stop", hits != 0, exp);
   endtask : ev

   initial begin
      #200000;
      num_errors++;
      close_out();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      for (k = 0; k < 6; k++) rd(8'(4 * k), 32'h0);
      rd(8'h18, 32'h0, cpl_pkg::RESP_SLVERR);
      wr(8'h18, 32'hffff_ffff, cpl_pkg::RESP_SLVERR);
      for (g = 0; g < 2; g++) begin
         wr(cpl_pkg::OFF_CTRL, g ? 32'h0002_0000 : 32'h0000_5000);
         mreg = 32'h0;
         for (k = 0; k < 4; k++) begin
            lfsr = nx(lfsr);
            t = k ? lfsr[3:0] : 15;
            press(6'(g * 16 + t));
            mreg[t] = 1'b1;
            rd(g ? cpl_pkg::OFF_CADDR : cpl_pkg::OFF_CDATA, mreg);
            check("lamps", g ? addr_lamps : data_lamps, mreg);
         end
         if (g == 0) check("speaker", speaker_drive, mreg[15:13]);
         rd(g ? cpl_pkg::OFF_CDATA : cpl_pkg::OFF_CADDR, 32'h0);
         press(6'(32 + g));
         rd(g ? cpl_pkg::OFF_CADDR : cpl_pkg::OFF_CDATA, 32'h0);
      end
      for (s = 0; s < 11; s++) begin
         lfsr = nx(lfsr);
         src[s] <= lfsr;
      end
      for (s = 0; s < 4; s++) begin
         lfsr = nx(lfsr);
         asrc[s] <= {lfsr[3:0], lfsr};
      end
      for (m = 0; m < 2; m++) begin
         for (s = 0; s < 11; s++) begin
            wr(cpl_pkg::OFF_CTRL, 32'(s << 12) | 32'(m));
            tick(2);
            ex = ((m || s == 4) && s != 5) ? src[s] : 32'h0;
            check("data_lamps", data_lamps, ex);
            check("speaker", speaker_drive, ex[15:13]);
         end
         for (s = 0; s < 8; s++) begin
            wr(cpl_pkg::OFF_CTRL, 32'(s[1:0] << 16) | 32'(s[2] << 5) | 32'h200 | 32'(m));
            tick(2);
            r = s[1:0];
            ex = (r == 0) ? asrc[s[2] ? 0 : 2] : (m && r != 2) ? asrc[r] : 32'h0;
            check("addr_lamps", addr_lamps, ex);
         end
      end
      wr(cpl_pkg::OFF_RUNCTL, 32'h0000_4924);
      lfsr = nx(lfsr);
      ex = {12'h0, lfsr[3:0], lfsr};
      wr(cpl_pkg::OFF_BKPT, ex);
      rd(cpl_pkg::OFF_BKPT, ex);
      rd(cpl_pkg::OFF_RUNCTL, 32'h0000_4924);
      check("bkpt_mode", state_bkpt_mode, 8'h24);
      check("run_en", state_run_en & 8'hdb, 8'h92);
      asrc[0] <= ex[19:0];
      asrc[2] <= ~ex[19:0];
      active_state <= 3'h2;
      for (r = 0; r < 2; r++) begin
         for (t = 0; t < 3; t++) begin
            wr(cpl_pkg::OFF_CTRL, 32'(1 << (6 + t)) | 32'h200 | 32'(r << 5));
            for (k = 0; k < 3; k++) ev(k, r && k == t);
         end
      end
      active_state <= 3'h1;
      ev(2, 1'b0);
      ms_par_err <= 1'b1;
      cs_par_err <= 1'b1;
      for (m = 0; m < 2; m++) begin
         lfsr = nx(lfsr);
         cs_word_in <= {lfsr, ~lfsr};
         wr(cpl_pkg::OFF_CTRL, 32'h0000_001e | 32'(m));
         tick(2);
         check("step", step_major_cycle, m);
         check("cs_word", cs_word_out, m ? 32'h0 : cs_word_in);
         check("par_stop", parity_stop, !m);
         check("par_ind", {ms_par_ind, cs_par_ind}, 2'h3);
         n = 0;
         repeat (100) begin
            @(negedge core_clk);
            n += exec_autostart;
         end
         check("autostart", n, m ? 0 : 2);
         press(6'h22);
         press(6'h23);
         press(6'h22);
         check("even_parity", even_parity, m ? 2'h2 : 2'h0);
         press(6'h24, 8'h1e);
         check("left_ones", load_left_ones, m);
         tick(24);
         press(6'h26, 8'h1e);
         check("both_force", {load_msdata_ones, force_carry}, m ? 2'h3 : 2'h0);
         tick(24);
      end
      close_out();
   end
endmodule : console_panel_control_logic_tb
